// ### counter_meas.sv
// semi-period, pulse and frequency measurement engine of one general-purpose counter
// assumes gate, source and sample clock pins are asynchronous; the paired counter output and
// timebase ticks come from logic on the same clock; the stream sink drains one slot by ready
//
// How it works
// - buffered semi-period pushes count on every gate edge after the starting edge
// - captured counts leave through the stream port
// - counting starts only after arm command
// - starting level picks first semi-period delivered
// - pulse and semi-period share one interval timer
// - semi-period delivers each interval alone
// - pulse mode delivers high and low paired
// - sample clock for sample-clocked pulse and frequency, not semi-period or buffered pulse
// - one-counter period counts selected timebase
// - gate may come from fixed paired counter
// - high frequency: unknown on source, known pulse gate
// - pulse generator emits exactly N source periods
// - internal output feeds paired counter gate
// - averaging enable, reset value enabled
// - averaging counts T1 unknown, T2 timebase
// - non-averaging reports last complete period
// - single width stores on gate inactive, stops
// - armed while active waits for next activation
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/10ps
module counter_meas (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          resetn,
  // register port
  input  wire logic [meas_pkg::ADDR_W-1:0]   addr,
  input  wire logic [meas_pkg::W-1:0]        wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [meas_pkg::W-1:0]        rdata,
  // measured signals
  input  wire logic                          gate_in,
  input  wire logic                          source_in,
  input  wire logic                          sample_clk_in,
  input  wire logic                          programmable_function_pin,
  // paired counter and timebases
  input  wire logic                          paired_gate_in,
  input  wire logic                          timebase_fast_tick,
  input  wire logic                          timebase_mid_tick,
  input  wire logic                          timebase_slow_tick,
  output logic                               internal_out,
  // sample stream to host memory
  output logic                               stream_valid,
  input  wire logic                          stream_ready,
  output logic      [meas_pkg::W-1:0]        stream_data_a,
  output logic      [meas_pkg::W-1:0]        stream_data_b,
  output logic                               stream_paired,
  output logic                               stream_level
);
  logic [meas_pkg::CTRL_W-1:0] ctrl;
  logic [meas_pkg::W-1:0]      divide;
  logic [meas_pkg::STAT_W-1:0] stat;
  logic [meas_pkg::W-1:0]      last_count;
  meas_pkg::state_t            state;
  meas_pkg::mode_t             mode;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic       gate_d;
  logic       src_d;
  logic       samp_d;
  logic       gate_raw;
  logic       gate_lvl;
  logic       gate_rise;
  logic       gate_fall;
  logic       gate_edge;
  logic       tick;
  logic       samp_tick;
  logic       arm_cmd;
  logic       disarm_cmd;
  logic       first_hit;
  logic [meas_pkg::W-1:0] cnt;
  logic [meas_pkg::W-1:0] aux;
  logic [meas_pkg::W-1:0] cnt_inc;
  logic [meas_pkg::W-1:0] aux_inc;
  logic [meas_pkg::W-1:0] pair_hi;
  logic [meas_pkg::W-1:0] pair_lo;
  logic       half;
  logic       fresh;
  logic       push;
  logic       push_pair;
  logic       push_level;
  logic [meas_pkg::W-1:0] push_a;
  logic [meas_pkg::W-1:0] push_b;
  logic       ovf_set;
  logic       sat_set;
  logic       ovr_set;
  logic       pin_gate_s1;
  logic       pin_gate_s2;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // gate, source and sample clock are asynchronous: two flops each
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {sample_clk_in, source_in, gate_in};
      sync2 <= sync1;
    end
  end

  // paired output is same-clock logic, no synchroniser; function pin is an alternative gate
  assign gate_raw  = ctrl[meas_pkg::CTRL_GATE_PAIR] ? paired_gate_in : (sync2[0] | pin_gate_s2);
  assign gate_lvl  = gate_raw ^ ctrl[meas_pkg::CTRL_GATE_INV];
  assign gate_rise = gate_lvl & ~gate_d;
  assign gate_fall = ~gate_lvl & gate_d;
  assign gate_edge = gate_rise | gate_fall;
  assign samp_tick = ctrl[meas_pkg::CTRL_SAMP_FALL] ? (samp_d & ~sync2[2]) : (sync2[2] & ~samp_d);
  assign mode      = meas_pkg::mode_t'(ctrl[meas_pkg::CTRL_MODE_LSB +: meas_pkg::CTRL_MODE_W]);
  assign arm_cmd    = wr & (addr == meas_pkg::REG_CMD) & wdata[meas_pkg::CMD_ARM];
  assign disarm_cmd = wr & (addr == meas_pkg::REG_CMD) & wdata[meas_pkg::CMD_DISARM];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_gate_s1 <= 1'b0;
      pin_gate_s2 <= 1'b0;
    end else begin
      pin_gate_s1 <= programmable_function_pin;
      pin_gate_s2 <= pin_gate_s1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gate_d <= 1'b0;
      src_d  <= 1'b0;
      samp_d <= 1'b0;
    end else begin
      gate_d <= gate_lvl;
      src_d  <= sync2[1];
      samp_d <= sync2[2];
    end
  end

  // onboard timebase or any known-rate signal on the source pin
  always_comb begin
    case (ctrl[meas_pkg::CTRL_SRC_LSB +: 2])
      meas_pkg::SRC_PIN:     tick = sync2[1] & ~src_d;
      meas_pkg::SRC_TB_FAST: tick = timebase_fast_tick;
      meas_pkg::SRC_TB_MID:  tick = timebase_mid_tick;
      meas_pkg::SRC_TB_SLOW: tick = timebase_slow_tick;
      default:               tick = 1'b0;
    endcase
  end

  // saturating increments, never wrap
  assign cnt_inc = (tick && cnt != meas_pkg::COUNT_MAX) ? cnt + meas_pkg::ONE : cnt;
  assign aux_inc = (gate_rise && aux != meas_pkg::COUNT_MAX) ? aux + meas_pkg::ONE : aux;

  // edge that opens the first reported interval
  always_comb begin
    case (mode)
      meas_pkg::MODE_SEMI_BUF:  first_hit = ctrl[meas_pkg::CTRL_SEMI_FIRST] ? gate_rise : gate_fall;
      meas_pkg::MODE_PULSE_BUF,
      meas_pkg::MODE_PULSE_SC:  first_hit = ctrl[meas_pkg::CTRL_PULSE_FIRST] ? gate_rise : gate_fall;
      meas_pkg::MODE_PULSE_GEN: first_hit = tick;
      default:                  first_hit = gate_rise;
    endcase
  end

  // ----------------------------------------
  // measurement engine
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= meas_pkg::ST_IDLE;
      cnt <= '0;
      aux <= '0;
      pair_hi <= '0;
      pair_lo <= '0;
      half <= 1'b0;
      fresh <= 1'b0;
      push <= 1'b0;
      push_pair <= 1'b0;
      push_level <= 1'b0;
      push_a <= '0;
      push_b <= '0;
      ovf_set <= 1'b0;
      sat_set <= 1'b0;
      internal_out <= 1'b0;
    end else begin
      push <= 1'b0;
      ovf_set <= 1'b0;
      sat_set <= (state == meas_pkg::ST_RUN) && tick && (cnt == meas_pkg::COUNT_MAX);
      if (disarm_cmd) begin
        state <= meas_pkg::ST_IDLE;
        internal_out <= 1'b0;
      end else if (arm_cmd) begin
        cnt <= '0;
        aux <= '0;
        half <= 1'b0;
        fresh <= 1'b0;
        internal_out <= 1'b0;
        state <= (mode == meas_pkg::MODE_FREQ_SC) ? meas_pkg::ST_RUN : meas_pkg::ST_WAIT;
      end else if (state == meas_pkg::ST_WAIT) begin
        // only a fresh transition starts, never a level already active
        if (first_hit) begin
          state <= meas_pkg::ST_RUN;
          cnt <= '0;
          internal_out <= (mode == meas_pkg::MODE_PULSE_GEN);
        end
      end else if (state == meas_pkg::ST_RUN) begin
        cnt <= cnt_inc;
        case (mode)
          meas_pkg::MODE_SINGLE_WIDTH: begin
            // also the high frequency count N over a known gate pulse
            if (gate_fall) begin
              push <= 1'b1;
              push_pair <= 1'b0;
              push_level <= 1'b1;
              push_a <= cnt_inc;
              push_b <= '0;
              state <= meas_pkg::ST_DONE;
            end
          end
          meas_pkg::MODE_PERIOD: begin
            if (gate_rise) begin
              push <= 1'b1;
              push_pair <= 1'b0;
              push_level <= 1'b1;
              push_a <= cnt_inc;
              push_b <= '0;
              state <= meas_pkg::ST_DONE;
            end
          end
          meas_pkg::MODE_SEMI_BUF: begin
            if (gate_edge) begin
              push <= 1'b1;
              push_pair <= 1'b0;
              push_level <= gate_d;
              push_a <= cnt_inc;
              push_b <= '0;
              cnt <= '0;
            end
          end
          meas_pkg::MODE_PULSE_BUF,
          meas_pkg::MODE_PULSE_SC: begin
            // same interval timer as semi-period, grouped in pairs
            if (gate_edge) begin
              cnt <= '0;
              half <= ~half;
              if (!half) begin
                aux <= cnt_inc;
              end else begin
                pair_hi <= gate_d ? cnt_inc : aux;
                pair_lo <= gate_d ? aux : cnt_inc;
                fresh <= 1'b1;
                if (mode == meas_pkg::MODE_PULSE_BUF) begin
                  push <= 1'b1;
                  push_pair <= 1'b1;
                  push_level <= 1'b1;
                  push_a <= gate_d ? cnt_inc : aux;
                  push_b <= gate_d ? aux : cnt_inc;
                end
              end
            end
            // sample clock is honoured here in MODE_PULSE_SC only and in frequency mode, never in semi-period
            if (mode == meas_pkg::MODE_PULSE_SC && samp_tick) begin
              if (fresh) begin
                push <= 1'b1;
                push_pair <= 1'b1;
                push_level <= 1'b1;
                push_a <= pair_hi;
                push_b <= pair_lo;
                fresh <= gate_edge & half;
              end else begin
                ovf_set <= 1'b1;
              end
            end
          end
          meas_pkg::MODE_PULSE_GEN: begin
            if (tick && cnt_inc >= divide) begin
              internal_out <= 1'b0;
              state <= meas_pkg::ST_DONE;
            end
          end
          meas_pkg::MODE_FREQ_SC: begin
            if (ctrl[meas_pkg::CTRL_AVG]) begin
              aux <= aux_inc;
              if (samp_tick) begin
                cnt <= '0;
                aux <= '0;
                if (aux_inc != '0) begin
                  push <= 1'b1;
                  push_pair <= 1'b1;
                  push_level <= 1'b1;
                  push_a <= aux_inc;
                  push_b <= cnt_inc;
                end else begin
                  ovf_set <= 1'b1;
                end
              end
            end else begin
              // period in source ticks; first rise after arm only opens it
              if (gate_rise) begin
                cnt <= '0;
                half <= 1'b1;
                if (half) begin
                  pair_lo <= cnt_inc;
                  fresh <= 1'b1;
                end
              end
              if (samp_tick) begin
                // a period ending in this very cycle still counts
                if ((gate_rise && half) || fresh) begin
                  push <= 1'b1;
                  push_pair <= 1'b1;
                  push_level <= 1'b1;
                  push_a <= meas_pkg::ONE;
                  push_b <= (gate_rise && half) ? cnt_inc : pair_lo;
                  fresh <= 1'b0;
                end else begin
                  ovf_set <= 1'b1;
                end
              end
            end
          end
          default: begin
            state <= meas_pkg::ST_IDLE;
            internal_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // stream slot toward host memory
  // ----------------------------------------
  // one slot only: the sink must keep up, a lost sample is flagged
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stream_valid <= 1'b0;
      stream_data_a <= '0;
      stream_data_b <= '0;
      stream_paired <= 1'b0;
      stream_level <= 1'b0;
      ovr_set <= 1'b0;
    end else begin
      ovr_set <= push & stream_valid & ~stream_ready;
      if (push && !(stream_valid && !stream_ready)) begin
        stream_valid <= 1'b1;
        stream_data_a <= push_a;
        stream_data_b <= push_b;
        stream_paired <= push_pair;
        stream_level <= push_level;
      end else if (stream_ready) begin
        stream_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl <= meas_pkg::CTRL_RESET;
      divide <= meas_pkg::DIV_RESET;
      last_count <= '0;
    end else begin
      if (wr && addr == meas_pkg::REG_CTRL) begin
        ctrl <= wdata[meas_pkg::CTRL_W-1:0];
      end
      if (wr && addr == meas_pkg::REG_DIV) begin
        divide <= wdata;
      end
      if (push) begin
        last_count <= push_a;
      end
    end
  end

  // armed and done follow state; the other flags are sticky, write one to clear; a set in the same cycle wins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stat <= '0;
    end else begin
      stat[meas_pkg::STAT_ARMED] <= (state == meas_pkg::ST_WAIT) || (state == meas_pkg::ST_RUN);
      stat[meas_pkg::STAT_DONE]  <= (state == meas_pkg::ST_DONE);
      if (ovf_set) begin
        stat[meas_pkg::STAT_MEAS_OVF] <= 1'b1;
      end else if (wr && addr == meas_pkg::REG_STAT && wdata[meas_pkg::STAT_MEAS_OVF]) begin
        stat[meas_pkg::STAT_MEAS_OVF] <= 1'b0;
      end
      if (sat_set) begin
        stat[meas_pkg::STAT_SAT] <= 1'b1;
      end else if (wr && addr == meas_pkg::REG_STAT && wdata[meas_pkg::STAT_SAT]) begin
        stat[meas_pkg::STAT_SAT] <= 1'b0;
      end
      if (ovr_set) begin
        stat[meas_pkg::STAT_STREAM_OVR] <= 1'b1;
      end else if (wr && addr == meas_pkg::REG_STAT && wdata[meas_pkg::STAT_STREAM_OVR]) begin
        stat[meas_pkg::STAT_STREAM_OVR] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        meas_pkg::REG_CTRL:  rdata <= {{(meas_pkg::W-meas_pkg::CTRL_W){1'b0}}, ctrl};
        meas_pkg::REG_DIV:   rdata <= divide;
        meas_pkg::REG_STAT:  rdata <= {{(meas_pkg::W-meas_pkg::STAT_W){1'b0}}, stat};
        meas_pkg::REG_COUNT: rdata <= last_count;
        default:             rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_semi_push;
    @(posedge clock) disable iff (!resetn)
    (state == meas_pkg::ST_RUN && mode == meas_pkg::MODE_SEMI_BUF && gate_edge && !arm_cmd && !disarm_cmd)
      |=> push && !push_pair ##1 stream_valid;
  endproperty
  a_semi_push: assert property (p_semi_push) else $error("semi-period edge not pushed");

  property p_stream;
    @(posedge clock) disable iff (!resetn)
    (push && !(stream_valid && !stream_ready)) |=> stream_valid && stream_data_a == $past(push_a);
  endproperty
  a_stream: assert property (p_stream) else $error("sample not presented on stream");

  property p_idle_quiet;
    @(posedge clock) disable iff (!resetn)
    (state == meas_pkg::ST_IDLE && !arm_cmd) |=> !push && !internal_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("activity while not armed");

  property p_pulse_paired;
    @(posedge clock) disable iff (!resetn)
    (push && (mode == meas_pkg::MODE_PULSE_BUF || mode == meas_pkg::MODE_PULSE_SC)) |-> push_pair;
  endproperty
  a_pulse_paired: assert property (p_pulse_paired) else $error("pulse sample not paired");

  property p_single_stop;
    @(posedge clock) disable iff (!resetn)
    (state == meas_pkg::ST_RUN && mode == meas_pkg::MODE_SINGLE_WIDTH && gate_fall && !arm_cmd && !disarm_cmd)
      |=> state == meas_pkg::ST_DONE && push ##1 !push;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single width did not stop");

  property p_wait_rise;
    @(posedge clock) disable iff (!resetn)
    (state == meas_pkg::ST_WAIT && mode == meas_pkg::MODE_SINGLE_WIDTH && !gate_rise && !arm_cmd && !disarm_cmd)
      |=> state == meas_pkg::ST_WAIT;
  endproperty
  a_wait_rise: assert property (p_wait_rise) else $error("started without activation edge");

  property p_gen_high;
    @(posedge clock) disable iff (!resetn)
    (state == meas_pkg::ST_RUN && mode == meas_pkg::MODE_PULSE_GEN) |-> internal_out;
  endproperty
  a_gen_high: assert property (p_gen_high) else $error("generated pulse dropped early");

  property p_ovf_flag;
    @(posedge clock) disable iff (!resetn)
    ovf_set |=> stat[meas_pkg::STAT_MEAS_OVF];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("measurement overflow not flagged");

  property p_sat_flag;
    @(posedge clock) disable iff (!resetn)
    (state == meas_pkg::ST_RUN && tick && cnt == meas_pkg::COUNT_MAX && !arm_cmd && !disarm_cmd)
      |-> cnt_inc == meas_pkg::COUNT_MAX ##1 sat_set ##1 stat[meas_pkg::STAT_SAT];
  endproperty
  a_sat_flag: assert property (p_sat_flag) else $error("count wrapped or not flagged");
endmodule

// ### meas_pkg.sv
// constants, register map and enumerations of the semi-period / frequency measurement counter
// assumes a single 250 MHz clock domain and a plain strobe register port
package meas_pkg;
  localparam int W = 32;
  localparam int ADDR_W = 5;
  localparam int CTRL_W = 11;
  localparam int STAT_W = 5;
  localparam int CLOCK_MHZ = 250;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL  = 5'h00;
  localparam logic [ADDR_W-1:0] REG_CMD   = 5'h04;
  localparam logic [ADDR_W-1:0] REG_DIV   = 5'h08;
  localparam logic [ADDR_W-1:0] REG_STAT  = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_COUNT = 5'h10;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_MODE_W     = 3;
  localparam int CTRL_SEMI_FIRST = 3;
  localparam int CTRL_PULSE_FIRST = 4;
  localparam int CTRL_AVG        = 5;
  localparam int CTRL_SRC_LSB    = 6;
  localparam int CTRL_GATE_PAIR  = 8;
  localparam int CTRL_GATE_INV   = 9;
  localparam int CTRL_SAMP_FALL  = 10;
  localparam int CMD_ARM         = 0;
  localparam int CMD_DISARM      = 1;
  localparam int STAT_ARMED      = 0;
  localparam int STAT_DONE       = 1;
  localparam int STAT_MEAS_OVF   = 2;
  localparam int STAT_SAT        = 3;
  localparam int STAT_STREAM_OVR = 4;

  // ----------------------------------------
  // reset values and limits
  // ----------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h020;
  localparam logic [W-1:0]      DIV_RESET  = 32'h00000002;
  localparam logic [W-1:0]      COUNT_MAX  = 32'hffffffff;
  localparam logic [W-1:0]      ONE        = 32'h00000001;

  // ----------------------------------------
  // source selection
  // ----------------------------------------
  localparam logic [1:0] SRC_PIN     = 2'h0;
  localparam logic [1:0] SRC_TB_FAST = 2'h1;
  localparam logic [1:0] SRC_TB_MID  = 2'h2;
  localparam logic [1:0] SRC_TB_SLOW = 2'h3;

  typedef enum logic [2:0] {
    MODE_SINGLE_WIDTH = 3'h0,
    MODE_SEMI_BUF     = 3'h1,
    MODE_PULSE_SC     = 3'h2,
    MODE_PULSE_BUF    = 3'h3,
    MODE_FREQ_SC      = 3'h5,
    MODE_PERIOD       = 3'h6,
    MODE_PULSE_GEN    = 3'h7
  } mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b11,
    ST_DONE = 2'b10
  } state_t;
endpackage

// ### far_side.sv
// far-side model: gate signal under test and a known timebase tick
// assumes a free-running bench clock; gate edges land on tick phase 0
`timescale 1ns/10ps
module far_side (
  // clock
  input  wire logic clock,
  // signals under test
  output logic      gate_in,
  output logic      tick
);
  logic [1:0] phase = 2'h0;

  // ----------------------------------------
  // timebase, one tick every four cycles
  // ----------------------------------------
  always_ff @(posedge clock) begin
    phase <= phase + 2'h1;
  end
  // ticks kept one cycle off gate edges so counts are exact
  assign tick = (phase == 2'h1);

  // ----------------------------------------
  // gate level for n cycles, n a multiple of 4
  // ----------------------------------------
  initial gate_in = 1'b0;
  task automatic level(input logic v, input int n);
    do @(posedge clock); while (phase !== 2'h3);
    gate_in <= v;
    repeat (n - 4) @(posedge clock);
  endtask
endmodule

// ### counter_semiperiod_frequency_meas_bench.sv
// self-checking bench of the measurement counter
// assumes far_side drives gate and timebase; stream sink always ready
`timescale 1ns/10ps
`define CHK(act, exp) begin tests_run++; if ((act) !== (exp)) begin miscompares++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, act, exp); end end
module counter_semiperiod_frequency_meas_bench;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        gate_in;
  logic        tick;
  logic        stream_valid;
  logic [31:0] stream_data_a;
  logic [31:0] stream_data_b;
  logic        stream_paired;
  logic        stream_level;
  logic        samp = 1'b0;
  logic        gen;
  int          gen_hi = 0;
  logic [65:0] got[$];
  logic [31:0] d;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;

  initial forever #2 clock = ~clock;

  far_side u_far_side (.clock(clock), .gate_in(gate_in), .tick(tick));

  counter_meas u_counter_meas (
    .clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .gate_in(gate_in), .source_in(tick), .sample_clk_in(samp),
    .programmable_function_pin(1'b0), .paired_gate_in(1'b0), .timebase_fast_tick(tick),
    .timebase_mid_tick(tick), .timebase_slow_tick(1'b0), .internal_out(gen),
    .stream_valid(stream_valid), .stream_ready(1'b1), .stream_data_a(stream_data_a),
    .stream_data_b(stream_data_b), .stream_paired(stream_paired), .stream_level(stream_level));

  // ----------------------------------------
  // stream sink and run limit
  // ----------------------------------------
  always @(posedge clock) begin
    if (stream_valid === 1'b1) got.push_back({stream_paired, stream_level, stream_data_b, stream_data_a});
    if (gen === 1'b1) gen_hi++;
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // register port tasks
  // ----------------------------------------
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    v = rdata;
  endtask
  function automatic logic [65:0] smp(logic p, logic l, logic [31:0] b, logic [31:0] a);
    return {p, l, b, a};
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    rd_reg(meas_pkg::REG_CTRL, d);
    `CHK(d, {21'h0, meas_pkg::CTRL_RESET})
    rd_reg(meas_pkg::REG_DIV, d);
    `CHK(d, meas_pkg::DIV_RESET)
    rd_reg(5'h14, d);
    `CHK(d, 32'h0)
    $display("test registers done");
    // semi-period, both starting levels; gate idles low at arm
    for (int f = 0; f < 2; f++) begin
      got.delete();
      wr_reg(meas_pkg::REG_CTRL, 32'h041 | (f << 3));
      wr_reg(meas_pkg::REG_CMD, 32'h1);
      repeat (2) begin
        u_far_side.level(1'b1, 40);
        u_far_side.level(1'b0, 24);
      end
      repeat (12) @(posedge clock);
      `CHK(got[0], f ? smp(0, 1, 0, 10) : smp(0, 0, 0, 6))
      `CHK(got[1], f ? smp(0, 0, 0, 6) : smp(0, 1, 0, 10))
      wr_reg(meas_pkg::REG_CMD, 32'h2);
      $display("test semi-period level %0d done", f);
    end
    // pulse buffered, high first: one paired beat per high/low
    got.delete();
    wr_reg(meas_pkg::REG_CTRL, 32'h053);
    wr_reg(meas_pkg::REG_CMD, 32'h1);
    u_far_side.level(1'b1, 40);
    u_far_side.level(1'b0, 24);
    u_far_side.level(1'b1, 8);
    repeat (12) @(posedge clock);
    `CHK(got[0], smp(1, 1, 6, 10))
    wr_reg(meas_pkg::REG_CMD, 32'h2);
    $display("test pulse done");
    // single width armed while gate active: first pulse skipped
    u_far_side.level(1'b0, 8);
    got.delete();
    wr_reg(meas_pkg::REG_CTRL, 32'h040);
    u_far_side.level(1'b1, 8);
    wr_reg(meas_pkg::REG_CMD, 32'h1);
    u_far_side.level(1'b0, 8);
    u_far_side.level(1'b1, 32);
    u_far_side.level(1'b0, 32);
    u_far_side.level(1'b1, 40);
    u_far_side.level(1'b0, 8);
    repeat (12) @(posedge clock);
    `CHK(got.size(), 1)
    `CHK(got[0], smp(0, 1, 0, 8))
    rd_reg(meas_pkg::REG_COUNT, d);
    `CHK(d, 32'h8)
    rd_reg(meas_pkg::REG_STAT, d);
    `CHK(d[meas_pkg::STAT_DONE], 1'b1)
    $display("test single width done");
    // period, rise to rise: 16 cycles hold 4 timebase ticks
    got.delete();
    wr_reg(meas_pkg::REG_CTRL, 32'h046);
    wr_reg(meas_pkg::REG_CMD, 32'h1);
    repeat (2) begin
      u_far_side.level(1'b1, 8);
      u_far_side.level(1'b0, 8);
    end
    `CHK(got[0], smp(0, 1, 0, 4))
    $display("test period done");
    // averaged frequency: first sample has no gate rise, then 2 rises over 8 ticks
    got.delete();
    wr_reg(meas_pkg::REG_CTRL, 32'h065);
    wr_reg(meas_pkg::REG_CMD, 32'h1);
    u_far_side.level(1'b0, 8);
    samp <= 1'b1;
    repeat (2) begin
      u_far_side.level(1'b1, 8);
      samp <= 1'b0;
      u_far_side.level(1'b0, 8);
    end
    samp <= 1'b1;
    repeat (8) @(posedge clock);
    `CHK(got[0], smp(1, 1, 8, 2))
    rd_reg(meas_pkg::REG_STAT, d);
    `CHK(d[meas_pkg::STAT_MEAS_OVF], 1'b1)
    wr_reg(meas_pkg::REG_CMD, 32'h2);
    $display("test frequency done");
    // generated pulse lasts divide timebase periods of 4 cycles each
    wr_reg(meas_pkg::REG_CTRL, 32'h047);
    wr_reg(meas_pkg::REG_CMD, 32'h1);
    repeat (16) @(posedge clock);
    `CHK(gen_hi, 4 * meas_pkg::DIV_RESET)
    $display("test pulse generator done");
    end_of_test();
  end
endmodule
